// file: core/rfc_flow_ctl.v
`timescale 1ns/1ps
`include "rfc_defines.vh"

module rfc_flow_ctl #(
  parameter FILL_W = 16,
  parameter JAM_W  = 13
) (
  input  wire              CLOCK,
  input  wire              RESET,
  input  wire [7:0]        REG_ADDR,
  input  wire              REG_WR,
  input  wire              REG_RD,
  input  wire [31:0]       REG_WDATA,
  output reg  [31:0]       REG_RDATA,
  input  wire              FRAME_DROPPED,
  output wire              DROP_HALF_EVENT,
  output wire              MAC_CSR_REQ,
  output reg               MAC_CSR_READ,
  output reg  [7:0]        MAC_CSR_ADDR,
  output reg  [31:0]       MAC_CSR_WDATA,
  input  wire              MAC_CSR_ACK,
  input  wire [31:0]       MAC_CSR_RDATA,
  input  wire              TX_ENABLED,
  input  wire              FULL_DUPLEX,
  input  wire              SPEED_100,
  input  wire [FILL_W-1:0] RX_FIFO_LEVEL,
  input  wire              RX_FRAME_START,
  input  wire              RX_ADDR_VALID,
  input  wire              RX_IS_GROUP,
  input  wire              RX_IS_ALL_STATION,
  input  wire              RX_IS_OWN,
  output wire              PAUSE_REQ,
  output reg               PAUSE_ZERO,
  input  wire              PAUSE_ACK,
  output wire              BACK_PRESSURE
);

  // Indirect access states
  localparam [2:0] AC_IDLE = 3'b001;
  localparam [2:0] AC_REQ  = 3'b010;
  localparam [2:0] AC_DONE = 3'b100;

  // Pause states
  localparam [3:0] PS_ARMED   = 4'b0001;
  localparam [3:0] PS_SEND_HI = 4'b0010;
  localparam [3:0] PS_PAUSED  = 4'b0100;
  localparam [3:0] PS_SEND_LO = 4'b1000;

  // Register decode, shared by read and write paths
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Threshold in bytes from a 64-byte unit field
  function [FILL_W-1:0] to_bytes;
    input [7:0] units;
    begin
      to_bytes = {{(FILL_W-8){1'b0}}, units} << `RFC_FILL_UNIT_SHIFT;
    end
  endfunction

  wire        wr_cmd;
  wire        wr_data;
  wire        wr_cfg;
  wire        rd_tally;
  wire [31:0] tally;

  reg         pending;
  reg         rnw;
  reg  [7:0]  csr_addr;
  reg  [31:0] csr_data;
  reg  [2:0]  ac_state;
  reg  [2:0]  next_ac_state;

  reg  [7:0]  upper_fill_threshold;
  reg  [7:0]  lower_fill_threshold;
  reg  [3:0]  jam_duration_select;
  reg         throttle_on_group_frames;
  reg         throttle_on_all_station_frames;
  reg         throttle_on_own_frames;
  reg         throttle_on_every_frame;

  reg  [3:0]  ps_state;
  reg  [3:0]  next_ps_state;

  wire        throttle_any;
  wire        fill_high;
  wire        fill_low;
  wire        class_match;
  wire        jam_start;
  wire        jam_active;
  wire        jam_every;
  wire        jam_class;
  wire        pause_sending;
  wire [31:0] cmd_word;
  wire [31:0] cfg_word;
  reg  [31:0] next_rdata;

  assign wr_cmd   = REG_WR & hit(REG_ADDR, `RFC_OFS_CMD);
  assign wr_data  = REG_WR & hit(REG_ADDR, `RFC_OFS_DATA);
  assign wr_cfg   = REG_WR & hit(REG_ADDR, `RFC_OFS_CFG);
  assign rd_tally = REG_RD & hit(REG_ADDR, `RFC_OFS_TALLY);

  rfc_drop_tally #(
    .WIDTH (32)
  ) u_tally (
    .clk           (CLOCK),
    .rst           (RESET),
    .frame_dropped (FRAME_DROPPED),
    .read_clear    (rd_tally),
    .count         (tally),
    .half_event    (DROP_HALF_EVENT)
  );

  // Reserved bits are never stored, so they read back as zero
  assign cmd_word = {pending,
                     rnw,
                     22'h000000,
                     csr_addr};
  assign cfg_word = {8'h00,
                     upper_fill_threshold,
                     lower_fill_threshold,
                     jam_duration_select,
                     throttle_on_group_frames,
                     throttle_on_all_station_frames,
                     throttle_on_own_frames,
                     throttle_on_every_frame};

  // Read selection shared by every register
  always @* begin
    next_rdata = 32'h00000000;
    case (1'b1)
      hit(REG_ADDR, `RFC_OFS_TALLY): next_rdata = tally;
      hit(REG_ADDR, `RFC_OFS_CMD):   next_rdata = cmd_word;
      hit(REG_ADDR, `RFC_OFS_DATA):  next_rdata = csr_data;
      hit(REG_ADDR, `RFC_OFS_CFG):   next_rdata = cfg_word;
      default:                       next_rdata = 32'h00000000;
    endcase
  end

  // Register read; the tally clears in the same cycle it is captured
  always @(posedge CLOCK) begin
    if (RESET) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  // Indirect command and data registers
  // Read data lands in the data register on the acknowledge
  always @(posedge CLOCK) begin
    if (RESET) begin
      rnw      <= 1'b0;
      csr_addr <= 8'h00;
      csr_data <= `RFC_DATA_RST;
    end else begin
      // Writes while pending are dropped so the access stays coherent
      if (wr_cmd && !pending) begin
        rnw      <= REG_WDATA[`RFC_CMD_RNW];
        csr_addr <= REG_WDATA[`RFC_CMD_ADDR_HI:`RFC_CMD_ADDR_LO];
      end
      if (wr_data && !pending)
        csr_data <= REG_WDATA;
      else if (ac_state == AC_REQ && MAC_CSR_ACK && MAC_CSR_READ)
        csr_data <= MAC_CSR_RDATA;
    end
  end

  // Indirect access sequencer
  always @* begin
    next_ac_state = ac_state;
    case (ac_state)
      AC_IDLE: begin
        if (wr_cmd && REG_WDATA[`RFC_CMD_PENDING])
          next_ac_state = AC_REQ;
      end
      AC_REQ: begin
        if (MAC_CSR_ACK)
          next_ac_state = AC_DONE;
      end
      AC_DONE: next_ac_state = AC_IDLE;
      default: next_ac_state = AC_IDLE;
    endcase
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      ac_state      <= AC_IDLE;
      pending       <= 1'b0;
      MAC_CSR_READ  <= 1'b0;
      MAC_CSR_ADDR  <= 8'h00;
      MAC_CSR_WDATA <= 32'h00000000;
    end else begin
      ac_state <= next_ac_state;
      if (ac_state == AC_IDLE && next_ac_state == AC_REQ) begin
        pending       <= 1'b1;
        // Launch uses the fields written in the same cycle
        MAC_CSR_READ  <= REG_WDATA[`RFC_CMD_RNW];
        MAC_CSR_ADDR  <= REG_WDATA[`RFC_CMD_ADDR_HI:`RFC_CMD_ADDR_LO];
        MAC_CSR_WDATA <= csr_data;
      end else if (ac_state == AC_REQ && MAC_CSR_ACK) begin
        pending <= 1'b0;
      end
    end
  end

  assign MAC_CSR_REQ = (ac_state == AC_REQ);

  // Flow control configuration
  // Config writes are taken even while an indirect access is pending
  always @(posedge CLOCK) begin
    if (RESET) begin
      upper_fill_threshold           <= 8'h00;
      lower_fill_threshold           <= 8'h00;
      jam_duration_select            <= 4'h0;
      throttle_on_group_frames       <= 1'b0;
      throttle_on_all_station_frames <= 1'b0;
      throttle_on_own_frames         <= 1'b0;
      throttle_on_every_frame        <= 1'b0;
    end else if (wr_cfg) begin
      upper_fill_threshold <= REG_WDATA[`RFC_CFG_UPPER_HI:`RFC_CFG_UPPER_LO];
      lower_fill_threshold <= REG_WDATA[`RFC_CFG_LOWER_HI:`RFC_CFG_LOWER_LO];
      jam_duration_select  <= REG_WDATA[`RFC_CFG_DUR_HI:`RFC_CFG_DUR_LO];
      throttle_on_group_frames       <= REG_WDATA[`RFC_CFG_GROUP];
      throttle_on_all_station_frames <= REG_WDATA[`RFC_CFG_ALLSTA];
      throttle_on_own_frames         <= REG_WDATA[`RFC_CFG_OWN];
      throttle_on_every_frame        <= REG_WDATA[`RFC_CFG_EVERY];
    end
  end

  assign throttle_any = throttle_on_every_frame | throttle_on_group_frames |
                        throttle_on_all_station_frames | throttle_on_own_frames;

  // Lower threshold is trusted to sit below the upper one
  // A zero upper threshold counts as always reached
  assign fill_high = (RX_FIFO_LEVEL >= to_bytes(upper_fill_threshold));
  assign fill_low  = (RX_FIFO_LEVEL <  to_bytes(lower_fill_threshold));

  // Full duplex pause sequencing
  always @* begin
    next_ps_state = ps_state;
    case (ps_state)
      PS_ARMED: begin
        if (FULL_DUPLEX && TX_ENABLED && throttle_on_every_frame && fill_high)
          next_ps_state = PS_SEND_HI;
      end
      PS_SEND_HI: begin
        if (!TX_ENABLED)
          next_ps_state = PS_ARMED;
        else if (PAUSE_ACK)
          next_ps_state = PS_PAUSED;
      end
      PS_PAUSED: begin
        // Only reached after a real pause went out
        if (TX_ENABLED && throttle_any && fill_low)
          next_ps_state = PS_SEND_LO;
      end
      PS_SEND_LO: begin
        if (!TX_ENABLED)
          next_ps_state = PS_PAUSED;
        else if (PAUSE_ACK)
          next_ps_state = PS_ARMED;
      end
      default: next_ps_state = PS_ARMED;
    endcase
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      ps_state   <= PS_ARMED;
      PAUSE_ZERO <= 1'b0;
    end else begin
      ps_state   <= next_ps_state;
      PAUSE_ZERO <= (next_ps_state == PS_SEND_LO);
    end
  end

  assign pause_sending = (ps_state == PS_SEND_HI) | (ps_state == PS_SEND_LO);

  // Request drops at once if the transmitter goes away
  assign PAUSE_REQ = TX_ENABLED & pause_sending;

  // Half duplex back pressure
  assign class_match = (throttle_on_group_frames & RX_IS_GROUP) |
                       (throttle_on_all_station_frames & RX_IS_ALL_STATION) |
                       (throttle_on_own_frames & RX_IS_OWN);

  // Every-frame mode jams at the preamble and ignores the class bits
  assign jam_every = throttle_on_every_frame & RX_FRAME_START;
  assign jam_class = ~throttle_on_every_frame & RX_ADDR_VALID & class_match;
  // A jam starts only when the fill is at or above the upper threshold; a running jam ignores later fill
  assign jam_start = ~FULL_DUPLEX & TX_ENABLED & fill_high &
                     (jam_every | jam_class);

  // Duplex change or transmitter loss cuts a jam short

  rfc_jam_timer #(
    .CNT_W (JAM_W)
  ) u_jam (
    .clk       (CLOCK),
    .rst       (RESET),
    .start     (jam_start),
    .abort     (FULL_DUPLEX | ~TX_ENABLED),
    .dur_sel   (jam_duration_select),
    .speed_100 (SPEED_100),
    .active    (jam_active)
  );

  assign BACK_PRESSURE = jam_active & TX_ENABLED & ~FULL_DUPLEX;

endmodule

// file: core/rfc_defines.vh
`ifndef RFC_DEFINES_VH
`define RFC_DEFINES_VH

// Register byte offsets
`define RFC_OFS_TALLY       8'ha0
`define RFC_OFS_CMD         8'ha4
`define RFC_OFS_DATA        8'ha8
`define RFC_OFS_CFG         8'hac

// Reset values
`define RFC_TALLY_RST       32'h00000000
`define RFC_DATA_RST        32'h00000000
`define RFC_CMD_RST         32'h00000000
`define RFC_CFG_RST         32'h00000000

// Command register fields
`define RFC_CMD_PENDING     31
`define RFC_CMD_RNW         30
`define RFC_CMD_ADDR_HI     7
`define RFC_CMD_ADDR_LO     0

// Configuration register fields
`define RFC_CFG_UPPER_HI    23
`define RFC_CFG_UPPER_LO    16
`define RFC_CFG_LOWER_HI    15
`define RFC_CFG_LOWER_LO    8
`define RFC_CFG_DUR_HI      7
`define RFC_CFG_DUR_LO      4
`define RFC_CFG_GROUP       3
`define RFC_CFG_ALLSTA      2
`define RFC_CFG_OWN         1
`define RFC_CFG_EVERY       0

// Threshold unit: 64 bytes, as a left shift
`define RFC_FILL_UNIT_SHIFT 6

// Timing
`define RFC_CLK_PERIOD_NS   4
`define RFC_TICK_NS         100
`define RFC_TICK_CYCLES     (`RFC_TICK_NS / `RFC_CLK_PERIOD_NS)
`define RFC_JAM_MIN_US      5
`define RFC_JAM_STEP_US     50
`define RFC_JAM_SEL3_US     25
`define RFC_JAM_SLOW_NS     2200
`define RFC_JAM_SLOW_TICKS  (`RFC_JAM_SLOW_NS / `RFC_TICK_NS)
`define RFC_TICKS_PER_US    (1000 / `RFC_TICK_NS)

`endif

// file: core/rfc_drop_tally.v
`timescale 1ns/1ps
`include "rfc_defines.vh"

module rfc_drop_tally #(
  parameter WIDTH = 32
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             frame_dropped,
  input  wire             read_clear,
  output reg  [WIDTH-1:0] count,
  output reg              half_event
);

  wire [WIDTH-1:0] next_count;

  // A drop in the reading cycle survives the clear
  assign next_count = read_clear ? {{(WIDTH-1){1'b0}}, frame_dropped}
                                 : count + {{(WIDTH-1){1'b0}}, frame_dropped};

  always @(posedge clk) begin
    if (rst) begin
      count      <= `RFC_TALLY_RST;
      half_event <= 1'b0;
    end else begin
      count      <= next_count;
      half_event <= ~count[WIDTH-1] & next_count[WIDTH-1] & ~read_clear;
    end
  end

endmodule

// file: core/rfc_jam_timer.v
`timescale 1ns/1ps
`include "rfc_defines.vh"

module rfc_jam_timer #(
  parameter CNT_W = 13
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       start,
  input  wire       abort,
  input  wire [3:0] dur_sel,
  input  wire       speed_100,
  output wire       active
);

  localparam integer TICK_LAST_I = `RFC_TICK_CYCLES - 1;
  localparam [4:0]   TICK_LAST   = TICK_LAST_I[4:0];

  reg  [4:0]       div;
  reg  [CNT_W-1:0] remain;
  wire             tick;

  // Duration in 100 ns ticks
  function [CNT_W-1:0] jam_ticks;
    input [3:0]  sel;
    input        fast;
    reg   [31:0] us;
    reg   [31:0] ticks;
    begin
      if (sel < 4'h3)
        us = `RFC_JAM_MIN_US * ({28'h0, sel} + 32'h1);
      else if (sel == 4'h3)
        us = `RFC_JAM_SEL3_US;
      else
        us = `RFC_JAM_STEP_US * ({28'h0, sel} - 32'h3);
      ticks = us * `RFC_TICKS_PER_US;
      if (!fast)
        ticks = ticks + `RFC_JAM_SLOW_TICKS;
      jam_ticks = ticks[CNT_W-1:0];
    end
  endfunction

  assign tick   = (div == TICK_LAST);
  assign active = (remain != {CNT_W{1'b0}});

  always @(posedge clk) begin
    if (rst || abort) begin
      div    <= 5'h0;
      remain <= {CNT_W{1'b0}};
    end else if (start) begin
      // Divider restarts so the first tick is a full one
      div    <= 5'h0;
      remain <= jam_ticks(dur_sel, speed_100);
    end else begin
      div <= tick ? 5'h0 : div + 5'h1;
      if (tick && active)
        remain <= remain - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// file: verif/rfc_flow_ctl_checker.sv
`timescale 1ns/1ps
module rfc_flow_ctl_checker (
  input wire        CLOCK,
  input wire        RESET,
  input wire [7:0]  REG_ADDR,
  input wire        REG_WR,
  input wire        REG_RD,
  input wire [31:0] REG_WDATA,
  input wire [31:0] REG_RDATA,
  input wire        FRAME_DROPPED,
  input wire        DROP_HALF_EVENT,
  input wire        MAC_CSR_REQ,
  input wire        MAC_CSR_READ,
  input wire [7:0]  MAC_CSR_ADDR,
  input wire [31:0] MAC_CSR_WDATA,
  input wire        MAC_CSR_ACK,
  input wire        TX_ENABLED,
  input wire        FULL_DUPLEX,
  input wire        RX_FRAME_START,
  input wire        RX_ADDR_VALID,
  input wire        PAUSE_REQ,
  input wire        PAUSE_ZERO,
  input wire        PAUSE_ACK,
  input wire        BACK_PRESSURE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  property p_start;
    REG_WR && REG_ADDR == 8'ha4 && REG_WDATA[31] && !MAC_CSR_REQ && !$past(MAC_CSR_REQ)
      |=> MAC_CSR_REQ && MAC_CSR_READ == $past(REG_WDATA[30])
      && MAC_CSR_ADDR == $past(REG_WDATA[7:0]);
  endproperty
  a_start: assert property (p_start) else $error("access not started");
  property p_req_hold;
    MAC_CSR_REQ && !MAC_CSR_ACK |=> MAC_CSR_REQ && $stable(MAC_CSR_READ)
      && $stable(MAC_CSR_ADDR) && $stable(MAC_CSR_WDATA);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  property p_ack_drop;
    MAC_CSR_REQ && MAC_CSR_ACK |=> !MAC_CSR_REQ;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request kept");
  property p_clear_read;
    REG_RD && REG_ADDR == 8'ha0 && !FRAME_DROPPED ##1 REG_RD && REG_ADDR == 8'ha0
      |=> REG_RDATA == 32'h0;
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("tally not cleared");
  property p_half;
    DROP_HALF_EVENT |-> $past(FRAME_DROPPED) ##1 !DROP_HALF_EVENT;
  endproperty
  a_half: assert property (p_half) else $error("bad half event");
  property p_tx_off;
    !TX_ENABLED |-> !PAUSE_REQ ##1 !BACK_PRESSURE;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("throttle with tx off");
  property p_pause_hold;
    PAUSE_REQ && !PAUSE_ACK |=> !TX_ENABLED || PAUSE_REQ && $stable(PAUSE_ZERO);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause dropped");
  property p_pause_once;
    PAUSE_REQ && PAUSE_ACK |=> !PAUSE_REQ;
  endproperty
  a_pause_once: assert property (p_pause_once) else $error("pause repeated");
  property p_fd_no_jam;
    FULL_DUPLEX |=> !BACK_PRESSURE;
  endproperty
  a_fd_no_jam: assert property (p_fd_no_jam) else $error("jam in full duplex");
  property p_jam_cause;
    $rose(BACK_PRESSURE) |-> $past(RX_FRAME_START || RX_ADDR_VALID);
  endproperty
  a_jam_cause: assert property (p_jam_cause) else $error("jam without frame");
endmodule

bind rfc_flow_ctl rfc_flow_ctl_checker u_chk (
  .CLOCK(CLOCK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FRAME_DROPPED(FRAME_DROPPED),
  .DROP_HALF_EVENT(DROP_HALF_EVENT), .MAC_CSR_REQ(MAC_CSR_REQ), .MAC_CSR_READ(MAC_CSR_READ),
  .MAC_CSR_ADDR(MAC_CSR_ADDR), .MAC_CSR_WDATA(MAC_CSR_WDATA), .MAC_CSR_ACK(MAC_CSR_ACK),
  .TX_ENABLED(TX_ENABLED), .FULL_DUPLEX(FULL_DUPLEX), .RX_FRAME_START(RX_FRAME_START),
  .RX_ADDR_VALID(RX_ADDR_VALID), .PAUSE_REQ(PAUSE_REQ), .PAUSE_ZERO(PAUSE_ZERO),
  .PAUSE_ACK(PAUSE_ACK), .BACK_PRESSURE(BACK_PRESSURE)
);

// file: verif/rfc_mac_model.sv
`timescale 1ns/1ps
module rfc_mac_model (
  input  wire        clk,
  input  wire        rst,
  input  wire [3:0]  lag,
  input  wire        req,
  input  wire        rd,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  output reg         ack,
  output reg  [31:0] rdata,
  input  wire        p_req,
  output reg         p_ack
);
  reg [31:0] mem [0:255];
  reg [3:0]  cnt;
  reg [3:0]  pcnt;
  always @(posedge clk) begin
    ack <= 1'h0;
    p_ack <= 1'h0;
    // Toggles when idle so stale data never passes
    rdata <= ~rdata;
    cnt <= 4'h0;
    pcnt <= 4'h0;
    if (rst) begin
      rdata <= 32'h0;
    end else begin
      if (req && !ack && cnt == lag) begin
        ack <= 1'h1;
        if (rd) begin
          rdata <= mem[addr];
        end else begin
          mem[addr] <= wdata;
        end
      end else if (req && !ack) begin
        cnt <= cnt + 4'h1;
      end
      if (p_req && !p_ack && pcnt == lag) begin
        p_ack <= 1'h1;
      end else if (p_req && !p_ack) begin
        pcnt <= pcnt + 4'h1;
      end
    end
  end
endmodule

// file: verif/rfc_flow_ctl_tb_top.sv
`timescale 1ns/1ps
module rfc_flow_ctl_tb_top;
  reg         clk  = 1'h0;
  reg         rst  = 1'h1;
  reg  [7:0]  ra   = 8'h0;
  reg         rw   = 1'h0;
  reg         rr   = 1'h0;
  reg  [31:0] wd   = 32'h0;
  reg         drop = 1'h0;
  reg         txe  = 1'h0;
  reg         fd   = 1'h0;
  reg         spd  = 1'h1;
  reg  [15:0] lvl  = 16'h0;
  reg         fst  = 1'h0;
  reg         av   = 1'h0;
  reg         grp  = 1'h0;
  reg         own  = 1'h0;
  reg         alls = 1'h0;
  reg  [3:0]  lag  = 4'h2;
  wire [31:0] rdo;
  wire        creq;
  wire        crd;
  wire [7:0]  cad;
  wire [31:0] cwd;
  wire        cack;
  wire [31:0] crdat;
  wire        preq;
  wire        pzero;
  wire        pack;
  wire        bp;
  wire        half;
  integer     fails = 0;
  integer     comparisons = 0;
  integer     nhi = 0;
  integer     nzero = 0;

  rfc_flow_ctl uut (
    .CLOCK(clk), .RESET(rst), .REG_ADDR(ra), .REG_WR(rw), .REG_RD(rr),
    .REG_WDATA(wd), .REG_RDATA(rdo), .FRAME_DROPPED(drop), .DROP_HALF_EVENT(half),
    .MAC_CSR_REQ(creq), .MAC_CSR_READ(crd), .MAC_CSR_ADDR(cad), .MAC_CSR_WDATA(cwd),
    .MAC_CSR_ACK(cack), .MAC_CSR_RDATA(crdat), .TX_ENABLED(txe), .FULL_DUPLEX(fd),
    .SPEED_100(spd), .RX_FIFO_LEVEL(lvl), .RX_FRAME_START(fst), .RX_ADDR_VALID(av),
    .RX_IS_GROUP(grp), .RX_IS_ALL_STATION(alls), .RX_IS_OWN(own), .PAUSE_REQ(preq),
    .PAUSE_ZERO(pzero), .PAUSE_ACK(pack), .BACK_PRESSURE(bp)
  );
  rfc_mac_model mac (
    .clk(clk), .rst(rst), .lag(lag), .req(creq), .rd(crd), .addr(cad), .wdata(cwd),
    .ack(cack), .rdata(crdat), .p_req(preq), .p_ack(pack)
  );

  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (preq && pack) begin
      if (pzero) nzero = nzero + 1;
      else nhi = nhi + 1;
    end
  end

  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      ra = a;
      wd = d;
      rw = 1'h1;
      step(1);
      rw = 1'h0;
      step(1);
    end
  endtask
  task rchk(input string nm, input [7:0] a, input [31:0] e);
    begin
      ra = a;
      rr = 1'h1;
      step(1);
      rr = 1'h0;
      chk(nm, e, rdo);
      step(1);
    end
  endtask
  task wait_idle;
    integer i;
    begin
      i = 0;
      ra = 8'ha4;
      rr = 1'h1;
      step(1);
      rr = 1'h0;
      // Poll at least once: the last read may predate the start
      while (i < 40 && rdo[31] !== 1'h0) begin
        i = i + 1;
        step(1);
        rr = 1'h1;
        step(1);
        rr = 1'h0;
      end
      chk("pending", 32'h0, {31'h0, rdo[31]});
      step(1);
    end
  endtask
  task jam(input s, input g, input o, input integer e);
    integer n;
    begin
      fst = s;
      av = !s;
      grp = g;
      own = o;
      step(1);
      fst = 1'h0;
      av = 1'h0;
      grp = 1'h0;
      own = 1'h0;
      n = 0;
      while (bp && n < 9000) begin
        n = n + 1;
        step(1);
      end
      chk("jam cycles", e, n);
      step(3);
    end
  endtask

  task t_regs;
    integer i;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        rchk("reset value", 8'ha0 + 8'h4 * i[7:0], 32'h0);
      end
      wr(8'hac, 32'hffffffff);
      rchk("config", 8'hac, 32'h00ffffff);
      wr(8'ha4, 32'h7fffffff);
      rchk("command", 8'ha4, 32'h400000ff);
      wr(8'ha8, 32'ha5a50f0f);
      rchk("data", 8'ha8, 32'ha5a50f0f);
      wr(8'hb0, 32'hffffffff);
      rchk("unmapped", 8'hb0, 32'h0);
      wr(8'hac, 32'h0);
      $display("test regs done");
    end
  endtask
  task t_tally;
    begin
      drop = 1'h1;
      step(5);
      drop = 1'h0;
      rchk("tally", 8'ha0, 32'h5);
      ra = 8'ha0;
      rr = 1'h1;
      step(1);
      drop = 1'h1;
      step(1);
      rr = 1'h0;
      drop = 1'h0;
      chk("cleared", 32'h0, rdo);
      step(1);
      rchk("tally", 8'ha0, 32'h1);
      chk("half event", 32'h0, {31'h0, half});
      $display("test tally done");
    end
  endtask
  task t_csr;
    begin
      lag = 4'h3;
      wr(8'ha8, 32'h12345678);
      wr(8'ha4, 32'h80000033);
      wait_idle;
      chk("mac write", 32'h12345678, mac.mem[8'h33]);
      lag = 4'h8;
      wr(8'ha4, 32'hc0000033);
      rchk("pending", 8'ha4, 32'hc0000033);
      wait_idle;
      rchk("mac read", 8'ha8, 32'h12345678);
      $display("test csr done");
    end
  endtask
  task t_pause;
    begin
      fd = 1'h1;
      txe = 1'h1;
      lag = 4'h2;
      wr(8'hac, 32'h00020101);
      lvl = 16'h7f;
      step(20);
      chk("pause", 32'h0, nhi);
      lvl = 16'h80;
      step(20);
      chk("pause", 32'h1, nhi);
      chk("zero pause", 32'h0, nzero);
      lvl = 16'h40;
      step(20);
      chk("zero pause", 32'h0, nzero);
      lvl = 16'h3f;
      step(20);
      chk("zero pause", 32'h1, nzero);
      txe = 1'h0;
      lvl = 16'hc8;
      step(20);
      chk("pause", 32'h1, nhi);
      txe = 1'h1;
      step(20);
      chk("pause", 32'h2, nhi);
      lvl = 16'h0;
      step(20);
      chk("zero pause", 32'h2, nzero);
      $display("test pause done");
    end
  endtask
  task t_jam;
    begin
      fd = 1'h0;
      wr(8'hac, 32'h00010008);
      lvl = 16'h40;
      jam(1'h0, 1'h0, 1'h1, 0);
      jam(1'h0, 1'h1, 1'h0, 1250);
      spd = 1'h0;
      jam(1'h0, 1'h1, 1'h0, 1800);
      spd = 1'h1;
      lvl = 16'h3f;
      jam(1'h0, 1'h1, 1'h0, 0);
      lvl = 16'h40;
      wr(8'hac, 32'h00010012);
      jam(1'h0, 1'h0, 1'h1, 2500);
      wr(8'hac, 32'h00010004);
      alls = 1'h1;
      jam(1'h0, 1'h0, 1'h0, 1250);
      alls = 1'h0;
      wr(8'hac, 32'h00010001);
      jam(1'h1, 1'h0, 1'h0, 1250);
      txe = 1'h0;
      jam(1'h1, 1'h0, 1'h0, 0);
      txe = 1'h1;
      fd = 1'h1;
      jam(1'h1, 1'h0, 1'h0, 0);
      $display("test jam done");
    end
  endtask

  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'h0;
    t_regs;
    t_tally;
    t_csr;
    t_pause;
    t_jam;
    report_and_stop;
  end
  // Tests take about 8300 cycles
  initial begin
    #200000;
    fails = fails + 1;
    report_and_stop;
  end
endmodule
